// ===== hw/timer_ch0_pkg.sv
// package: register map, field layout, mode codes and helpers of timer channel 0
// Operation
// - Selection code 000 keeps the register as output compare but leaves its pin as it is.
// - A-side code 001 drives the A pin low when the counter equals the A general register.
// - A-side code 010 drives the A pin high when the counter equals the A general register.
// - A-side code 011 inverts the A pin at each match of counter and A general register.
// - A-side code 100 captures the counter into the A register on each rising A pin edge.
// - A-side code 101 captures the counter into the A register on each falling A pin edge.
// - A-side codes 11x capture the counter into the A register on both A pin edges.
// - B-side codes 001, 010 and 011 drive the B pin low, high, or toggle it on a B match.
// - B-side codes 100, 101 and 11x capture on rising, falling or both B pin edges.
// - The A match request leaves the block only while the A enable bit is one.
// - The wrap request leaves the block only while the wrap enable bit is one.
// - The wrap flag sets when the counter passes ffff to 0000 or 0000 to ffff.
package timer_ch0_pkg;
  // register offsets on the byte port
  localparam logic [7:0] CTRL_OFS = 8'h60;
  localparam logic [7:0] PFS_OFS = 8'h65;
  localparam logic [7:0] IEN_OFS = 8'h66;
  localparam logic [7:0] STAT_OFS = 8'h67;
  localparam logic [7:0] CNT_HI_OFS = 8'h68;
  localparam logic [7:0] CNT_LO_OFS = 8'h69;
  localparam logic [7:0] A_GR_HI_OFS = 8'h6a;
  localparam logic [7:0] A_GR_LO_OFS = 8'h6b;
  localparam logic [7:0] B_GR_HI_OFS = 8'h6c;
  localparam logic [7:0] B_GR_LO_OFS = 8'h6d;
  // field positions
  localparam int PFS_A_LSB = 0;
  localparam int PFS_B_LSB = 4;
  localparam int BIT_A = 0;
  localparam int BIT_B = 1;
  localparam int BIT_WRAP = 2;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DOWN = 1;
  // reserved bits that read as one
  localparam logic [7:0] PFS_RSV = 8'h88;
  localparam logic [7:0] FLAG_RSV = 8'hf8;
  // reset values
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] FLAG_RESET = 3'h0;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] GR_RESET = 16'hffff;
  localparam logic [15:0] CNT_TOP = 16'hffff;
  // pin function codes
  localparam logic [2:0] MODE_HOLD = 3'h0;
  localparam logic [2:0] MODE_LOW = 3'h1;
  localparam logic [2:0] MODE_HIGH = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_RISE = 3'h4;
  localparam logic [2:0] MODE_FALL = 3'h5;

  // capture fires on the edge that the code selects
  function automatic logic cap_hit(input logic [2:0] m, input logic rise, input logic fall);
    return m[2] && (m[1] ? (rise || fall) : (m[0] ? fall : rise));
  endfunction : cap_hit

  // next pin level after a compare match
  function automatic logic pin_after(input logic [2:0] m, input logic cur);
    return (m == MODE_LOW) ? 1'b0 : (m == MODE_HIGH) ? 1'b1 : (m == MODE_TOGGLE) ? ~cur : cur;
  endfunction : pin_after
endpackage : timer_ch0_pkg

// ===== hw/timer_ch_if.sv
// interface: control and result signals between the channel core and one pin unit
`timescale 1ns/1ps
interface timer_ch_if;
  logic [2:0] mode;
  logic [15:0] cnt;
  logic cnt_step;
  logic [7:0] wdata;
  logic wr_hi;
  logic wr_lo;
  logic [15:0] gr;
  logic hit;
  logic rise;
  logic fall;
  modport ctl (output mode, cnt, cnt_step, wdata, wr_hi, wr_lo, input gr, hit, rise, fall);
  modport chan (input mode, cnt, cnt_step, wdata, wr_hi, wr_lo, output gr, hit, rise, fall);
endinterface : timer_ch_if

// ===== hw/timer_ch_unit.sv
// module: one general register with its pin, compare output and input capture
`timescale 1ns/1ps
module timer_ch_unit (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  output logic o_pin,
  output logic o_pin_oe,
  timer_ch_if.chan bus
);
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic level_ff;
  logic [15:0] gr_ff;
  logic pin_ff;
  logic oe_ff;
  logic stable;
  logic match;
  logic cap;

  ////////////////////////////////////////////////////////////////////////////////
  // pin input: three flops, a change counts once the last two agree
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      level_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= i_pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      level_ff <= stable ? sync3_ff : level_ff;
    end
  end

  // edge pulses from the filtered level
  assign stable = (sync2_ff == sync3_ff);
  assign bus.rise = stable && sync3_ff && !level_ff;
  assign bus.fall = stable && !sync3_ff && level_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // compare match only in output modes, capture on the selected edge
  assign match = bus.cnt_step && (bus.cnt == gr_ff) && !bus.mode[2];
  assign cap = timer_ch0_pkg::cap_hit(bus.mode, bus.rise, bus.fall);
  assign bus.hit = match || cap;
  assign bus.gr = gr_ff;
  assign o_pin = pin_ff;
  assign o_pin_oe = oe_ff;

  // general register: capture wins over a software byte write
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      gr_ff <= timer_ch0_pkg::GR_RESET;
    else if (cap)
      gr_ff <= bus.cnt;
    else if (bus.wr_hi)
      gr_ff <= {bus.wdata, gr_ff[7:0]};
    else if (bus.wr_lo)
      gr_ff <= {gr_ff[15:8], bus.wdata};
  end

  // pin output: low, high, toggle or left alone on a match
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else
    begin
      oe_ff <= !bus.mode[2] && (bus.mode != timer_ch0_pkg::MODE_HOLD);
      if (match)
        pin_ff <= timer_ch0_pkg::pin_after(bus.mode, pin_ff);
    end
  end
endmodule : timer_ch_unit

// ===== hw/timer_ch0.sv
// module: timer channel 0 with pin function select, flags and interrupt enables
`timescale 1ns/1ps
module timer_ch0 #(
  parameter int TICK_DIV = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_a_pin,
  output logic o_a_pin,
  output logic o_a_pin_oe,
  input wire logic i_b_pin,
  output logic o_b_pin,
  output logic o_b_pin_oe,
  output logic o_a_match_irq,
  output logic o_b_match_irq,
  output logic o_wrap_irq,
  output logic o_irq
);
  localparam int DIV_W = $clog2(TICK_DIV) + 1;

  logic [DIV_W-1:0] div_ff;
  logic [1:0] ctrl_ff;
  logic [2:0] a_mode_ff;
  logic [2:0] b_mode_ff;
  logic [2:0] ien_ff;
  logic [2:0] stat_ff;
  logic [2:0] arm_ff;
  logic [15:0] cnt_ff;
  logic step_ff;
  logic [7:0] rdata_ff;
  logic a_irq_ff;
  logic b_irq_ff;
  logic wrap_irq_ff;
  logic irq_ff;

  logic tick;
  logic count;
  logic wrap;
  logic [DIV_W-1:0] nxt_div;
  logic [15:0] nxt_cnt;
  logic [2:0] nxt_stat;
  logic [2:0] nxt_arm;
  logic [2:0] set_flags;
  logic [2:0] clr_flags;
  logic [2:0] req;
  logic wr_ctrl;
  logic wr_pfs;
  logic wr_ien;
  logic wr_stat;
  logic rd_stat;
  logic wr_cnt_hi;
  logic wr_cnt_lo;
  logic [7:0] rd_mux;

  timer_ch_if a_if ();
  timer_ch_if b_if ();

  ////////////////////////////////////////////////////////////////////////////////
  // pin units for the A and B general registers
  timer_ch_unit u_a (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_a_pin),
    .o_pin(o_a_pin),
    .o_pin_oe(o_a_pin_oe),
    .bus(a_if.chan)
  );

  timer_ch_unit u_b (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_b_pin),
    .o_pin(o_b_pin),
    .o_pin_oe(o_b_pin_oe),
    .bus(b_if.chan)
  );

  // shared drive of both units
  assign a_if.mode = a_mode_ff;
  assign a_if.cnt = cnt_ff;
  assign a_if.cnt_step = step_ff;
  assign a_if.wdata = i_wdata;
  assign a_if.wr_hi = i_wr && (i_addr == timer_ch0_pkg::A_GR_HI_OFS);
  assign a_if.wr_lo = i_wr && (i_addr == timer_ch0_pkg::A_GR_LO_OFS);
  assign b_if.mode = b_mode_ff;
  assign b_if.cnt = cnt_ff;
  assign b_if.cnt_step = step_ff;
  assign b_if.wdata = i_wdata;
  assign b_if.wr_hi = i_wr && (i_addr == timer_ch0_pkg::B_GR_HI_OFS);
  assign b_if.wr_lo = i_wr && (i_addr == timer_ch0_pkg::B_GR_LO_OFS);

  ////////////////////////////////////////////////////////////////////////////////
  // register port decode
  assign wr_ctrl = i_wr && (i_addr == timer_ch0_pkg::CTRL_OFS);
  assign wr_pfs = i_wr && (i_addr == timer_ch0_pkg::PFS_OFS);
  assign wr_ien = i_wr && (i_addr == timer_ch0_pkg::IEN_OFS);
  assign wr_stat = i_wr && (i_addr == timer_ch0_pkg::STAT_OFS);
  assign rd_stat = i_rd && (i_addr == timer_ch0_pkg::STAT_OFS);
  assign wr_cnt_hi = i_wr && (i_addr == timer_ch0_pkg::CNT_HI_OFS);
  assign wr_cnt_lo = i_wr && (i_addr == timer_ch0_pkg::CNT_LO_OFS);

  // read selection, unmapped offsets read zero
  assign rd_mux =
    (i_addr == timer_ch0_pkg::CTRL_OFS) ? {6'h00, ctrl_ff} :
    (i_addr == timer_ch0_pkg::PFS_OFS) ?
      (timer_ch0_pkg::PFS_RSV | {1'b0, b_mode_ff, 1'b0, a_mode_ff}) :
    (i_addr == timer_ch0_pkg::IEN_OFS) ? (timer_ch0_pkg::FLAG_RSV | {5'h00, ien_ff}) :
    (i_addr == timer_ch0_pkg::STAT_OFS) ? (timer_ch0_pkg::FLAG_RSV | {5'h00, stat_ff}) :
    (i_addr == timer_ch0_pkg::CNT_HI_OFS) ? cnt_ff[15:8] :
    (i_addr == timer_ch0_pkg::CNT_LO_OFS) ? cnt_ff[7:0] :
    (i_addr == timer_ch0_pkg::A_GR_HI_OFS) ? a_if.gr[15:8] :
    (i_addr == timer_ch0_pkg::A_GR_LO_OFS) ? a_if.gr[7:0] :
    (i_addr == timer_ch0_pkg::B_GR_HI_OFS) ? b_if.gr[15:8] :
    (i_addr == timer_ch0_pkg::B_GR_LO_OFS) ? b_if.gr[7:0] : 8'h00;

  // read data stands in the cycle after the strobe only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= i_rd ? rd_mux : 8'h00;
  end
  assign o_rdata = rdata_ff;

  // control, pin function and enable registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_ff <= timer_ch0_pkg::CTRL_RESET;
      a_mode_ff <= timer_ch0_pkg::MODE_RESET;
      b_mode_ff <= timer_ch0_pkg::MODE_RESET;
      ien_ff <= timer_ch0_pkg::FLAG_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= i_wdata[1:0];
      if (wr_pfs)
      begin
        a_mode_ff <= i_wdata[timer_ch0_pkg::PFS_A_LSB +: 3];
        b_mode_ff <= i_wdata[timer_ch0_pkg::PFS_B_LSB +: 3];
      end
      if (wr_ien)
        ien_ff <= i_wdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // count rate divider, one-cycle tick
  assign tick = (div_ff == DIV_W'(TICK_DIV - 1));
  assign nxt_div = tick ? '0 : div_ff + DIV_W'(1);
  assign count = tick && ctrl_ff[timer_ch0_pkg::CTRL_RUN];

  // up or down count, wrap at either end
  assign wrap = count && (ctrl_ff[timer_ch0_pkg::CTRL_DOWN] ? (cnt_ff == timer_ch0_pkg::CNT_RESET)
                                                            : (cnt_ff == timer_ch0_pkg::CNT_TOP));
  assign nxt_cnt = wr_cnt_hi ? {i_wdata, cnt_ff[7:0]} :
                   wr_cnt_lo ? {cnt_ff[15:8], i_wdata} :
                   !count ? cnt_ff :
                   ctrl_ff[timer_ch0_pkg::CTRL_DOWN] ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_ff <= '0;
      cnt_ff <= timer_ch0_pkg::CNT_RESET;
      step_ff <= 1'b0;
    end
    else
    begin
      div_ff <= nxt_div;
      cnt_ff <= nxt_cnt;
      step_ff <= count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flags: set by hardware, cleared by a zero written after reading a one
  assign set_flags = {wrap, b_if.hit, a_if.hit};
  assign clr_flags = wr_stat ? (arm_ff & ~i_wdata[2:0]) : 3'h0;
  assign nxt_stat = (stat_ff & ~clr_flags) | set_flags;
  assign nxt_arm = rd_stat ? (arm_ff | stat_ff) : wr_stat ? 3'h0 : arm_ff & stat_ff;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stat_ff <= timer_ch0_pkg::FLAG_RESET;
      arm_ff <= timer_ch0_pkg::FLAG_RESET;
    end
    else
    begin
      stat_ff <= nxt_stat;
      arm_ff <= nxt_arm;
    end
  end

  // requests: flag AND enable, each held while both stay set
  assign req = stat_ff & ien_ff;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      a_irq_ff <= 1'b0;
      b_irq_ff <= 1'b0;
      wrap_irq_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      a_irq_ff <= req[timer_ch0_pkg::BIT_A];
      b_irq_ff <= req[timer_ch0_pkg::BIT_B];
      wrap_irq_ff <= req[timer_ch0_pkg::BIT_WRAP];
      irq_ff <= |req;
    end
  end
  assign o_a_match_irq = a_irq_ff;
  assign o_b_match_irq = b_irq_ff;
  assign o_wrap_irq = wrap_irq_ff;
  assign o_irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_a_match(logic [2:0] m);
    a_if.hit && (a_if.mode == m) && (a_mode_ff == m);
  endsequence

  sequence s_b_match(logic [2:0] m);
    b_if.hit && (b_if.mode == m);
  endsequence

  sequence s_both_set(int i);
    (stat_ff[i] && ien_ff[i]) [*2];
  endsequence

  hold_pin_mode_a : assert property (
    s_a_match(timer_ch0_pkg::MODE_HOLD) |=> $stable(o_a_pin) && !o_a_pin_oe)
    else $error("pin moved in hold mode");

  a_drive_low_a : assert property (
    s_a_match(timer_ch0_pkg::MODE_LOW) |=> !o_a_pin ##1 o_a_pin_oe)
    else $error("a pin not low after match");

  a_drive_high_a : assert property (
    s_a_match(timer_ch0_pkg::MODE_HIGH) |=> o_a_pin ##1 o_a_pin_oe)
    else $error("a pin not high after match");

  a_toggle_a : assert property (
    s_a_match(timer_ch0_pkg::MODE_TOGGLE) |=> (o_a_pin != $past(o_a_pin)))
    else $error("a pin did not toggle");

  a_rise_capture_a : assert property (
    (a_if.mode == timer_ch0_pkg::MODE_RISE) && a_if.rise |-> a_if.hit ##1
      (a_if.gr == $past(cnt_ff)) && stat_ff[timer_ch0_pkg::BIT_A])
    else $error("a rising capture missed");

  a_fall_capture_a : assert property (
    (a_if.mode == timer_ch0_pkg::MODE_FALL) && a_if.fall |=>
      (a_if.gr == $past(cnt_ff)) && stat_ff[timer_ch0_pkg::BIT_A])
    else $error("a falling capture missed");

  a_both_edges_a : assert property (
    (a_if.mode[2:1] == 2'b11) && (a_if.rise || a_if.fall) |=> (a_if.gr == $past(cnt_ff)))
    else $error("a both edge capture missed");

  b_compare_pin_a : assert property (
    (s_b_match(timer_ch0_pkg::MODE_LOW) |=> !o_b_pin) and
    (s_b_match(timer_ch0_pkg::MODE_HIGH) |=> o_b_pin) and
    (s_b_match(timer_ch0_pkg::MODE_TOGGLE) |=> (o_b_pin != $past(o_b_pin))))
    else $error("b pin wrong after match");

  b_capture_edge_a : assert property (
    b_if.mode[2] && b_if.hit |=> (b_if.gr == $past(cnt_ff)) && stat_ff[timer_ch0_pkg::BIT_B])
    else $error("b capture did not load counter");

  a_irq_gate_a : assert property (
    !ien_ff[timer_ch0_pkg::BIT_A] ##1 !ien_ff[timer_ch0_pkg::BIT_A] |-> !o_a_match_irq)
    else $error("a request passed while disabled");

  b_irq_gate_a : assert property (
    s_both_set(timer_ch0_pkg::BIT_B) |-> o_b_match_irq)
    else $error("b request not forwarded");

  wrap_irq_gate_a : assert property (
    !ien_ff[timer_ch0_pkg::BIT_WRAP] |=> !o_wrap_irq)
    else $error("wrap request passed while disabled");

  wrap_flag_set_a : assert property (
    count && !ctrl_ff[timer_ch0_pkg::CTRL_DOWN] && (cnt_ff == timer_ch0_pkg::CNT_TOP)
      && !wr_cnt_hi && !wr_cnt_lo |=> stat_ff[timer_ch0_pkg::BIT_WRAP] && (cnt_ff == 16'h0000))
    else $error("wrap flag not set on overflow");

  flag_one_write_a : assert property (
    wr_stat && i_wdata[timer_ch0_pkg::BIT_WRAP] && stat_ff[timer_ch0_pkg::BIT_WRAP]
      |=> stat_ff[timer_ch0_pkg::BIT_WRAP])
    else $error("writing one cleared a flag");

  irq_held_a : assert property (
    s_both_set(timer_ch0_pkg::BIT_WRAP) |-> o_wrap_irq && o_irq)
    else $error("request dropped while flag and enable set");

  a_fall_no_rise_a : assert property (
    (a_if.mode == timer_ch0_pkg::MODE_FALL) && a_if.rise |-> !a_if.hit)
    else $error("a falling mode captured a rise");

  a_rise_no_fall_a : assert property (
    (a_if.mode == timer_ch0_pkg::MODE_RISE) && a_if.fall |-> !a_if.hit)
    else $error("a rising mode captured a fall");

  b_hold_pin_a : assert property (
    s_b_match(timer_ch0_pkg::MODE_HOLD) |=> $stable(o_b_pin) && !o_b_pin_oe)
    else $error("b pin moved in hold mode");

  b_capture_undriven_a : assert property (
    b_if.mode[2] |=> !o_b_pin_oe)
    else $error("b pin driven in capture mode");

  a_irq_pass_a : assert property (
    s_both_set(timer_ch0_pkg::BIT_A) |-> o_a_match_irq)
    else $error("a request not forwarded");

  b_irq_block_a : assert property (
    !ien_ff[timer_ch0_pkg::BIT_B] |=> !o_b_match_irq)
    else $error("b request passed while disabled");

  wrap_down_flag_a : assert property (
    count && ctrl_ff[timer_ch0_pkg::CTRL_DOWN] && (cnt_ff == timer_ch0_pkg::CNT_RESET)
      && !wr_cnt_hi && !wr_cnt_lo |=> stat_ff[timer_ch0_pkg::BIT_WRAP]
      && (cnt_ff == timer_ch0_pkg::CNT_TOP))
    else $error("wrap flag not set on underflow");

  irq_idle_a : assert property (
    ((stat_ff & ien_ff) == 3'h0) |=> !o_irq)
    else $error("combined request without a source");
endmodule : timer_ch0

// ===== tb/tb_timer_ch0.sv
// testbench: register, compare, capture and interrupt checks of timer channel 0
`timescale 1ns/1ps
module tb_timer_ch0;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_a_pin = 1'b0;
  logic i_b_pin = 1'b0;
  logic [7:0] o_rdata;
  logic o_a_pin, o_a_pin_oe, o_b_pin, o_b_pin_oe;
  logic o_a_match_irq, o_b_match_irq, o_wrap_irq, o_irq;
  int miscompares = 0;
  int checks = 0;

  timer_ch0 #(.TICK_DIV(1)) timer_ch0_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_a_pin(i_a_pin),
    .o_a_pin(o_a_pin), .o_a_pin_oe(o_a_pin_oe), .i_b_pin(i_b_pin),
    .o_b_pin(o_b_pin), .o_b_pin_oe(o_b_pin_oe), .o_a_match_irq(o_a_match_irq),
    .o_b_match_irq(o_b_match_irq), .o_wrap_irq(o_wrap_irq), .o_irq(o_irq)
  );

  // 50 MHz clock
  always #10 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // verdict, compare and register port tasks
  task automatic final_report();
    if (miscompares == 0 && checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, what);
  endtask : rd_chk

  task automatic wr16(input logic [7:0] a_hi, input logic [15:0] v);
    wr(a_hi, v[15:8]);
    wr(a_hi + 8'h01, v[7:0]);
  endtask : wr16

  // read arms the set flags, the zero write then clears them
  task automatic clear_flags();
    logic [7:0] d;
    rd(timer_ch0_pkg::STAT_OFS, d);
    wr(timer_ch0_pkg::STAT_OFS, 8'h00);
    repeat (3) @(posedge i_clk);
  endtask : clear_flags

  // bounded wait for the A match request
  task automatic wait_irq();
    int n;
    for (n = 0; n < 60; n++)
    begin
      @(posedge i_clk);
      #1;
      if (o_a_match_irq === 1'b1)
        return;
    end
    miscompares++;
    $display("[FAIL] %0t no match request", $time);
    final_report();
  endtask : wait_irq

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_reset();
    chk({5'h0, o_irq, o_a_pin_oe, o_b_pin_oe}, 8'h00, "outputs after reset");
    rd_chk(timer_ch0_pkg::PFS_OFS, 8'h88, "pin function reset");
    rd_chk(timer_ch0_pkg::IEN_OFS, 8'hf8, "enables reset");
    rd_chk(timer_ch0_pkg::STAT_OFS, 8'hf8, "flags reset");
    rd_chk(timer_ch0_pkg::A_GR_HI_OFS, 8'hff, "general reg reset");
    rd_chk(8'h70, 8'h00, "unmapped read");
  endtask : test_reset

  task automatic test_compare();
    logic [2:0] codes [5] = '{3'h2, 3'h1, 3'h3, 3'h3, 3'h0};
    logic exp_pin;
    exp_pin = 1'b0;
    wr16(timer_ch0_pkg::A_GR_HI_OFS, 16'h0008);
    wr16(timer_ch0_pkg::B_GR_HI_OFS, 16'h0008);
    wr(timer_ch0_pkg::IEN_OFS, 8'h03);
    foreach (codes[k])
    begin
      wr(timer_ch0_pkg::PFS_OFS, {1'b0, codes[k], 1'b0, codes[k]});
      wr16(timer_ch0_pkg::CNT_HI_OFS, 16'h0000);
      clear_flags();
      wr(timer_ch0_pkg::CTRL_OFS, 8'h01);
      wait_irq();
      wr(timer_ch0_pkg::CTRL_OFS, 8'h00);
      // expected level after the match
      if (codes[k] == 3'h1)
        exp_pin = 1'b0;
      else if (codes[k] == 3'h2)
        exp_pin = 1'b1;
      else if (codes[k] == 3'h3)
        exp_pin = ~exp_pin;
      chk({7'h0, o_a_pin}, {7'h0, exp_pin}, "a pin");
      chk({7'h0, o_b_pin}, {7'h0, exp_pin}, "b pin");
      chk({7'h0, o_a_pin_oe}, {7'h0, codes[k] != 3'h0}, "a drive");
      chk({7'h0, o_b_match_irq}, 8'h01, "b request");
    end
  endtask : test_compare

  task automatic test_wrap_irq();
    int e;
    logic [7:0] reqs;
    wr(timer_ch0_pkg::PFS_OFS, 8'h00);
    wr(timer_ch0_pkg::IEN_OFS, 8'h00);
    wr16(timer_ch0_pkg::A_GR_HI_OFS, 16'h0000);
    wr16(timer_ch0_pkg::B_GR_HI_OFS, 16'h0000);
    wr16(timer_ch0_pkg::CNT_HI_OFS, 16'hfffd);
    clear_flags();
    wr(timer_ch0_pkg::CTRL_OFS, 8'h01);
    repeat (10) @(posedge i_clk);
    wr(timer_ch0_pkg::CTRL_OFS, 8'h00);
    rd_chk(timer_ch0_pkg::STAT_OFS, 8'hff, "flags after up wrap");
    wr(timer_ch0_pkg::STAT_OFS, 8'h07);
    rd_chk(timer_ch0_pkg::STAT_OFS, 8'hff, "flags after one write");
    wr(timer_ch0_pkg::STAT_OFS, 8'h00);
    rd_chk(timer_ch0_pkg::STAT_OFS, 8'hf8, "flags after clear");
    wr16(timer_ch0_pkg::CNT_HI_OFS, 16'h0002);
    wr(timer_ch0_pkg::CTRL_OFS, 8'h03);
    repeat (10) @(posedge i_clk);
    wr(timer_ch0_pkg::CTRL_OFS, 8'h00);
    rd_chk(timer_ch0_pkg::STAT_OFS, 8'hff, "flags after down wrap");
    // every enable combination against three set flags
    for (e = 0; e < 8; e++)
    begin
      wr(timer_ch0_pkg::IEN_OFS, e[7:0]);
      repeat (2) @(posedge i_clk);
      #1;
      reqs = {5'h0, o_wrap_irq, o_b_match_irq, o_a_match_irq};
      chk(reqs, e[7:0], "requests");
      chk({7'h0, o_irq}, {7'h0, e != 0}, "combined request");
    end
  endtask : test_wrap_irq

  task automatic test_capture();
    int m;
    logic rise, fall;
    logic [7:0] v;
    for (m = 4; m < 8; m++)
    begin
      v = 8'h20 + m[7:0];
      rise = (m != 5);
      fall = (m != 4);
      wr(timer_ch0_pkg::PFS_OFS, {1'b0, m[2:0], 1'b0, m[2:0]});
      wr16(timer_ch0_pkg::CNT_HI_OFS, {8'h01, v});
      repeat (8) @(posedge i_clk);
      clear_flags();
      @(posedge i_clk);
      i_a_pin <= 1'b1;
      i_b_pin <= 1'b1;
      repeat (8) @(posedge i_clk);
      rd_chk(timer_ch0_pkg::STAT_OFS, 8'hf8 | {6'h0, rise, rise}, "rising");
      chk({6'h0, o_a_pin_oe, o_b_pin_oe}, 8'h00, "capture drive");
      if (rise)
      begin
        rd_chk(timer_ch0_pkg::A_GR_HI_OFS, 8'h01, "a capture hi");
        rd_chk(timer_ch0_pkg::A_GR_LO_OFS, v, "a capture lo");
        rd_chk(timer_ch0_pkg::B_GR_LO_OFS, v, "b capture lo");
      end
      clear_flags();
      @(posedge i_clk);
      i_a_pin <= 1'b0;
      i_b_pin <= 1'b0;
      repeat (8) @(posedge i_clk);
      rd_chk(timer_ch0_pkg::STAT_OFS, 8'hf8 | {6'h0, fall, fall}, "falling");
      clear_flags();
    end
  endtask : test_capture

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    test_reset();
    test_compare();
    test_wrap_irq();
    test_capture();
    final_report();
  end
endmodule : tb_timer_ch0
